// >>> shared/tws_defines.vh
// constants for the two-wire slave front end
// assumes inclusion by bare name from core files
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// protocol states
`define TWS_ST_IDLE     3'h0
`define TWS_ST_ADDR     3'h1
`define TWS_ST_AACK     3'h2
`define TWS_ST_RX       3'h3
`define TWS_ST_RACK     3'h4
`define TWS_ST_RWAIT    3'h5
`define TWS_ST_TX       3'h6
`define TWS_ST_TACK     3'h7

// bit counter value of the eighth bit of a byte
`define TWS_LAST_BIT    3'h7
// counter start value
`define TWS_FIRST_BIT   3'h0
// general call address, never matched
`define TWS_GCALL_ADDR  7'h00
// control defaults
`define TWS_CTL_OFF     1'h0
`define TWS_ADDR_RST    7'h00
`define TWS_BYTE_RST    8'h00
// line index in the synchroniser vectors
`define TWS_LN_SCL      0
`define TWS_LN_SDA      1

`endif

// >>> core/tws_slave_unit.v
// two-wire slave front end: address match, byte shift, stretch, filter
// assumes an external master drives the clock line, pins are open drain
// resolved outside, and the control ports are on the same clock
// Function
// - compare seven received address bits against the programmed own address
// - general call address is never matched; a 10-bit header is compared like any seven-bit address
// - each byte is eight bits, most significant bit first
// - one-byte receive and transmit holding buffers, half duplex
// - works at 100 and 400 kbps given enough system clock
// - clock line only sampled, driven low only during stretch waits
// - soft reset level holds protocol idle and floats both lines
// - soft reset returns every control bit to default
// - bus-free request handling is off until its enable is set
// - enabled low request sets free flag, restarts protocol, floats lines
// - bus-free request leaves the control settings unchanged
// - stretch off by default; when on, hold clock low after byte and ack
// - async address detection off by default, active only when enabled
// - async match raises event and answers not-acknowledge
// - async detection bypasses the filter and blocks all data transfer
// - filter enable removes noise from both line inputs
// - start sets busy, own address sets selected, both cleared by stop
// - communication enabled and matched: acknowledge, follow direction bit
`timescale 1ns/10ps
`default_nettype none
`include "tws_defines.vh"

module tws_slave_unit
(
	input  wire       SYS_CLK,        // system clock
	input  wire       RST_B,          // async reset, active low
	input  wire       SCL_I,          // clock line level
	output reg        SCL_O,          // clock line drive value, always low
	output reg        SCL_OE,         // clock line drive enable
	input  wire       SDA_I,          // data line level
	output reg        SDA_O,          // data line drive value, always low
	output reg        SDA_OE,         // data line drive enable
	input  wire       BUS_FREE_REQUEST_N, // bus-free request pin, active low
	input  wire       SOFT_RESET_BIT, // soft reset level
	input  wire       CTL_WR,         // load control settings, pulse
	input  wire       FREE_REQUEST_ENABLE, // control: bus-free request enable
	input  wire       STRETCH_ENABLE, // control: clock stretch enable
	input  wire       ASYNC_ADDR_DETECT_ENABLE, // control: async detection
	input  wire       FILTER_ENABLE,  // control: noise filter enable
	input  wire       COMMUNICATION_ENABLE, // control: respond to address
	input  wire [6:0] OWN_ADDRESS_FIELD, // control: own address
	input  wire [7:0] TX_DATA,        // transmit byte
	input  wire       TX_WR,          // write transmit byte, pulse
	output reg        TX_EMPTY,       // transmit buffer wants data
	output reg  [7:0] RX_DATA,        // received byte
	output reg        RX_FULL,        // receive buffer holds a byte
	input  wire       RX_RD,          // receive byte taken, pulse
	output reg        BUSY,           // bus busy between start and stop
	output reg        SELECTED,       // own address seen since start
	output reg        RW_DIR,         // direction bit, 1 read by master
	output reg        FREE_REQUEST_FLAG, // bus-free request seen
	output reg        ASYNC_DET_FLAG, // async address match seen
	input  wire       ASYNC_DET_CLR   // clear async flag, pulse
);

	reg  [1:0] sync1_q;
	reg  [1:0] sync2_q;
	reg  [1:0] hist_q;
	reg  [1:0] filt_q;
	wire [1:0] filt_d;
	reg        bfr1_q;
	reg        bfr2_q;
	reg        en_free_q;
	reg        en_str_q;
	reg        en_async_q;
	reg        en_filt_q;
	reg        en_comm_q;
	reg  [6:0] own_q;
	reg  [2:0] state_q;
	reg  [2:0] cnt_q;
	reg        done_q;
	reg  [7:0] sh_q;
	reg  [7:0] tx_q;
	reg        nak_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_ev;
	wire       stop_ev;
	wire       free_req;
	wire       proto_rst;
	wire       addr_match;

	// two-flop synchroniser and two-sample filter per line; kept short so
	// the slave answers inside a four-clock low phase at eight clocks a bit
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_line
			// next filtered level: bypassed, or taken once two samples agree
			assign filt_d[gi] = (en_async_q || !en_filt_q) ? sync2_q[gi] :
				((sync2_q[gi] == hist_q[gi]) ? sync2_q[gi] : filt_q[gi]);
			always @(posedge SYS_CLK or negedge RST_B)
			begin
				if (!RST_B)
				begin
					sync1_q[gi] <= 1'b1;
					sync2_q[gi] <= 1'b1;
					hist_q[gi]  <= 1'b1;
					filt_q[gi]  <= 1'b1;
				end
				else
				begin
					sync1_q[gi] <= (gi == `TWS_LN_SCL) ? SCL_I : SDA_I;
					sync2_q[gi] <= sync1_q[gi];
					hist_q[gi]  <= sync2_q[gi];
					filt_q[gi]  <= filt_d[gi];
				end
			end
		end
	endgenerate

	// line events: next filtered level against the held one, saving a stage
	assign scl_rise = filt_d[`TWS_LN_SCL] & ~filt_q[`TWS_LN_SCL];
	assign scl_fall = ~filt_d[`TWS_LN_SCL] & filt_q[`TWS_LN_SCL];
	assign start_ev = filt_d[`TWS_LN_SCL] & filt_q[`TWS_LN_SCL] &
		~filt_d[`TWS_LN_SDA] & filt_q[`TWS_LN_SDA];
	assign stop_ev  = filt_d[`TWS_LN_SCL] & filt_q[`TWS_LN_SCL] &
		filt_d[`TWS_LN_SDA] & ~filt_q[`TWS_LN_SDA];
	// request is honoured only when enabled
	assign free_req  = en_free_q & ~bfr2_q;
	assign proto_rst = SOFT_RESET_BIT | free_req;
	// direction bit excluded, general call never matches
	assign addr_match = (sh_q[7:1] == own_q) && (own_q != `TWS_GCALL_ADDR);

	// request pin synchroniser and sticky flag
	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			bfr1_q            <= 1'b1;
			bfr2_q            <= 1'b1;
			FREE_REQUEST_FLAG <= 1'b0;
		end
		else
		begin
			bfr1_q <= BUS_FREE_REQUEST_N;
			bfr2_q <= bfr1_q;
			if (free_req)
				FREE_REQUEST_FLAG <= 1'b1;
			else if (SOFT_RESET_BIT)
				FREE_REQUEST_FLAG <= 1'b0;
		end
	end

	// control settings, defaulted by hard or soft reset only
	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			en_free_q  <= `TWS_CTL_OFF;
			en_str_q   <= `TWS_CTL_OFF;
			en_async_q <= `TWS_CTL_OFF;
			en_filt_q  <= `TWS_CTL_OFF;
			en_comm_q  <= `TWS_CTL_OFF;
			own_q      <= `TWS_ADDR_RST;
		end
		else if (SOFT_RESET_BIT)
		begin
			en_free_q  <= `TWS_CTL_OFF;
			en_str_q   <= `TWS_CTL_OFF;
			en_async_q <= `TWS_CTL_OFF;
			en_filt_q  <= `TWS_CTL_OFF;
			en_comm_q  <= `TWS_CTL_OFF;
			own_q      <= `TWS_ADDR_RST;
		end
		else if (CTL_WR) // bus-free request does not touch these
		begin
			en_free_q  <= FREE_REQUEST_ENABLE;
			en_str_q   <= STRETCH_ENABLE;
			en_async_q <= ASYNC_ADDR_DETECT_ENABLE;
			en_filt_q  <= FILTER_ENABLE;
			en_comm_q  <= COMMUNICATION_ENABLE;
			own_q      <= OWN_ADDRESS_FIELD;
		end
	end

	// protocol engine, buffers and line drivers
	always @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_q        <= `TWS_ST_IDLE;
			cnt_q          <= `TWS_FIRST_BIT;
			done_q         <= 1'b0;
			sh_q           <= `TWS_BYTE_RST;
			tx_q           <= `TWS_BYTE_RST;
			nak_q          <= 1'b0;
			TX_EMPTY       <= 1'b0;
			RX_DATA        <= `TWS_BYTE_RST;
			RX_FULL        <= 1'b0;
			BUSY           <= 1'b0;
			SELECTED       <= 1'b0;
			RW_DIR         <= 1'b0;
			ASYNC_DET_FLAG <= 1'b0;
			SCL_O          <= 1'b0;
			SCL_OE         <= 1'b0;
			SDA_O          <= 1'b0;
			SDA_OE         <= 1'b0;
		end
		else if (proto_rst)
		begin
			// restart protocol, float both lines
			state_q  <= `TWS_ST_IDLE;
			cnt_q    <= `TWS_FIRST_BIT;
			done_q   <= 1'b0;
			BUSY     <= 1'b0;
			SELECTED <= 1'b0;
			SCL_OE   <= 1'b0;
			SDA_OE   <= 1'b0;
			TX_EMPTY <= 1'b0;
			RX_FULL  <= 1'b0;
			if (SOFT_RESET_BIT)
				ASYNC_DET_FLAG <= 1'b0;
		end
		else
		begin
			// transmit buffer write, receive buffer read
			if (TX_WR)
			begin
				tx_q     <= TX_DATA;
				TX_EMPTY <= 1'b0;
			end
			if (RX_RD)
				RX_FULL <= 1'b0;
			if (ASYNC_DET_CLR)
				ASYNC_DET_FLAG <= 1'b0;
			if (stop_ev)
			begin
				// stop ends the transaction
				state_q  <= `TWS_ST_IDLE;
				BUSY     <= 1'b0;
				SELECTED <= 1'b0;
				SDA_OE   <= 1'b0;
				SCL_OE   <= 1'b0;
			end
			else if (start_ev)
			begin
				// start or repeated start
				state_q  <= `TWS_ST_ADDR;
				BUSY     <= 1'b1;
				SELECTED <= 1'b0;
				cnt_q    <= `TWS_FIRST_BIT;
				done_q   <= 1'b0;
				SDA_OE   <= 1'b0;
			end
			else
			begin
				case (state_q)
					`TWS_ST_ADDR, `TWS_ST_RX:
					begin
						if (scl_rise)
						begin
							sh_q   <= {sh_q[6:0], filt_d[`TWS_LN_SDA]};
							cnt_q  <= cnt_q + 3'h1;
							done_q <= (cnt_q == `TWS_LAST_BIT);
						end
						else if (scl_fall && done_q && state_q == `TWS_ST_ADDR)
						begin
							done_q <= 1'b0;
							// sh_q[7:1] is address, sh_q[0] direction
							if (addr_match)
							begin
								SELECTED <= 1'b1;
								RW_DIR   <= sh_q[0];
								if (en_async_q)
								begin
									// flag the match, leave the ack bit high
									ASYNC_DET_FLAG <= 1'b1;
									state_q        <= `TWS_ST_IDLE;
								end
								else if (en_comm_q)
								begin
									SDA_OE  <= 1'b1;
									state_q <= `TWS_ST_AACK;
								end
								else
									state_q <= `TWS_ST_IDLE;
							end
							else
								state_q <= `TWS_ST_IDLE;
						end
						else if (scl_fall && done_q)
						begin
							// byte complete, store and acknowledge
							done_q  <= 1'b0;
							RX_DATA <= sh_q;
							RX_FULL <= 1'b1;
							SDA_OE  <= 1'b1;
							state_q <= `TWS_ST_RACK;
						end
					end
					`TWS_ST_AACK:
					begin
						if (scl_fall)
						begin
							cnt_q <= `TWS_FIRST_BIT;
							if (!RW_DIR)
							begin
								SDA_OE  <= 1'b0;
								state_q <= `TWS_ST_RX;
							end
							else if (en_str_q && TX_EMPTY && !TX_WR)
							begin
								SDA_OE  <= 1'b0;
								SCL_OE  <= 1'b1;
								state_q <= `TWS_ST_TACK;
								nak_q   <= 1'b0;
							end
							else
							begin
								sh_q     <= tx_q;
								SDA_OE   <= ~tx_q[7];
								TX_EMPTY <= 1'b1;
								state_q  <= `TWS_ST_TX;
							end
						end
					end
					`TWS_ST_RACK:
					begin
						if (scl_fall)
						begin
							SDA_OE <= 1'b0;
							cnt_q  <= `TWS_FIRST_BIT;
							if (en_str_q && RX_FULL && !RX_RD)
							begin
								SCL_OE  <= 1'b1;
								state_q <= `TWS_ST_RWAIT;
							end
							else
								state_q <= `TWS_ST_RX;
						end
					end
					`TWS_ST_RWAIT:
					begin
						if (!RX_FULL)
						begin
							SCL_OE  <= 1'b0;
							state_q <= `TWS_ST_RX;
						end
					end
					`TWS_ST_TX:
					begin
						if (scl_fall)
						begin
							if (cnt_q == `TWS_LAST_BIT)
							begin
								SDA_OE  <= 1'b0;
								state_q <= `TWS_ST_TACK;
								nak_q   <= 1'b0;
							end
							else
							begin
								cnt_q  <= cnt_q + 3'h1;
								sh_q   <= {sh_q[6:0], 1'b0};
								SDA_OE <= ~sh_q[6];
							end
						end
					end
					`TWS_ST_TACK:
					begin
						if (SCL_OE)
						begin
							// stretched, waiting for a transmit byte
							if (!TX_EMPTY)
							begin
								sh_q     <= tx_q;
								SDA_OE   <= ~tx_q[7];
								TX_EMPTY <= 1'b1;
								SCL_OE   <= 1'b0;
								cnt_q    <= `TWS_FIRST_BIT;
								state_q  <= `TWS_ST_TX;
							end
						end
						else if (scl_rise)
							nak_q <= filt_d[`TWS_LN_SDA];
						else if (scl_fall)
						begin
							cnt_q <= `TWS_FIRST_BIT;
							if (nak_q)
								state_q <= `TWS_ST_IDLE;
							else if (en_str_q && TX_EMPTY && !TX_WR)
								SCL_OE <= 1'b1;
							else
							begin
								sh_q     <= tx_q;
								SDA_OE   <= ~tx_q[7];
								TX_EMPTY <= 1'b1;
								state_q  <= `TWS_ST_TX;
							end
						end
					end
					default:
					begin
						SDA_OE <= 1'b0;
						SCL_OE <= 1'b0;
					end
				endcase
			end
			// hardware set wins over software clear
			if (!stop_ev && !start_ev && state_q == `TWS_ST_RX && scl_fall && done_q)
				RX_FULL <= 1'b1;
		end
	end

endmodule // tws_slave_unit

`default_nettype wire

// >>> sim/tws_bm.sv
// bus master model for the two-wire slave bench
// assumes pull-ups on both lines, resolved in the bench
`timescale 1ns/10ps
`default_nettype none
module tws_bm
(
	output logic scl_dn, // pull clock line low
	output logic sda_dn, // pull data line low
	input  wire logic scl, // resolved clock line
	input  wire logic sda, // resolved data line
	output logic hang    // stretch never ended
);
	// lines released at power up
	initial
	begin
		scl_dn = 0;
		sda_dn = 0;
		hang = 0;
	end
	// release clock, wait out a stretch under a bound
	task hi;
		int n;
		scl_dn = 0;
		n = 0;
		while (!scl && n < 2000)
		begin
			#8;
			n++;
		end
		if (!scl) hang = 1;
	endtask
	// one 64 ns bit, eight system clocks
	task bitx(input logic b, output logic r);
		sda_dn = !b;
		#16;
		hi;
		#16;
		r = sda;
		#16;
		scl_dn = 1;
		#16;
	endtask
	// data falls while clock high
	task start;
		#5;
		sda_dn = 1;
		#32;
		scl_dn = 1;
		#16;
	endtask
	// data rises while clock high
	task stop;
		sda_dn = 1;
		#16;
		hi;
		#32;
		sda_dn = 0;
		#64;
	endtask
	// data line pulse caught by a single system clock sample
	task glitch;
		#2;
		sda_dn = 1;
		#4;
		sda_dn = 0;
		#58;
	endtask
	// byte out msb first, then slave ack
	task wrb(input logic [7:0] d, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		a = !r;
	endtask
	// byte in msb first, then own ack or nak
	task rdb(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(nak, r);
	endtask
endmodule // tws_bm
`default_nettype wire

// >>> sim/tws_slave_unit_sva.sv
// checker for the two-wire slave front end
// assumes binding to tws_slave_unit ports
`timescale 1ns/10ps
`default_nettype none
module tws_sva_chk
(
	input wire SYS_CLK,           // clock
	input wire RST_B,             // reset
	input wire SCL_I,             // clock line
	input wire SDA_I,             // data line
	input wire SOFT_RESET_BIT,    // soft reset
	input wire TX_WR,             // tx write
	input wire SCL_O,             // clock value
	input wire SCL_OE,            // clock drive
	input wire SDA_O,             // data value
	input wire SDA_OE,            // data drive
	input wire TX_EMPTY,          // tx empty
	input wire RX_FULL,           // rx full
	input wire BUSY,              // bus busy
	input wire SELECTED,          // selected
	input wire RW_DIR,            // direction
	input wire FREE_REQUEST_FLAG, // bus-free flag
	input wire ASYNC_DET_FLAG     // async flag
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	// line conditions
	sequence s_start; SCL_I && $past(SCL_I) && $fell(SDA_I) && !SOFT_RESET_BIT
		##1 SCL_I && !SDA_I && !SOFT_RESET_BIT; endsequence
	sequence s_stop; SCL_I && $past(SCL_I) && $rose(SDA_I); endsequence
	sequence s_nak; !SDA_OE [*8]; endsequence
	property p_start; s_start |-> ##[1:6] BUSY; endproperty
	a_start: assert property (p_start) else $error("busy not set");
	property p_stop; s_stop |-> ##[1:6] !BUSY; endproperty
	a_stop: assert property (p_stop) else $error("busy not cleared");
	property p_sel; $rose(SELECTED) |-> BUSY; endproperty
	a_sel: assert property (p_sel) else $error("selected while idle");
	property p_drv; SCL_OE || SDA_OE |-> !SCL_O && !SDA_O && BUSY; endproperty
	a_drv: assert property (p_drv) else $error("line driven high");
	property p_str; SCL_OE && !FREE_REQUEST_FLAG |-> SELECTED; endproperty
	a_str: assert property (p_str) else $error("stretch unselected");
	property p_srst; SOFT_RESET_BIT |=> !(SCL_OE || SDA_OE || BUSY || SELECTED
		|| FREE_REQUEST_FLAG || ASYNC_DET_FLAG); endproperty
	a_srst: assert property (p_srst) else $error("soft reset ignored");
	property p_acd; $rose(ASYNC_DET_FLAG) |-> s_nak; endproperty
	a_acd: assert property (p_acd) else $error("async match acked");
	property p_tx; TX_WR && !SOFT_RESET_BIT |=> !TX_EMPTY; endproperty
	a_tx: assert property (p_tx) else $error("tx empty stuck");
	property p_rx; $rose(RX_FULL) |-> SELECTED && !RW_DIR; endproperty
	a_rx: assert property (p_rx) else $error("rx outside write");
	property p_bff; $rose(FREE_REQUEST_FLAG) |-> ##[0:1] !SCL_OE && !SDA_OE; endproperty
	a_bff: assert property (p_bff) else $error("lines held on free");
endmodule // tws_sva_chk
bind tws_slave_unit tws_sva_chk tws_sva_chk_i (.SYS_CLK, .RST_B, .SCL_I, .SDA_I,
	.SOFT_RESET_BIT, .TX_WR, .SCL_O, .SCL_OE, .SDA_O, .SDA_OE, .TX_EMPTY, .RX_FULL,
	.BUSY, .SELECTED, .RW_DIR, .FREE_REQUEST_FLAG, .ASYNC_DET_FLAG);
`default_nettype wire

// >>> sim/test_tws_slave_unit.sv
// bench for the two-wire slave front end
// assumes tws_bm as the bus master, pull-ups on both lines
`timescale 1ns/10ps
`default_nettype none
module test_tws_slave_unit;
	logic clk = 0, rst_b = 0, bfr_n = 1, srst = 0, ctl_wr = 0;
	logic tx_wr = 0, rx_rd = 0, aclr = 0, ack;
	logic [4:0] cf = 0; // free, stretch, async, filter, comm
	logic [6:0] own = 0;
	logic [7:0] txd = 0, d;
	wire m_scl, m_sda, hang, scl, sda, scl_o, scl_oe, sda_o, sda_oe;
	wire tx_empty, rx_full, busy, sel, rw, frf, adf;
	wire [7:0] rx_data;
	int err_count = 0, tests_run = 0;
	logic [19:0] tab [0:4] = '{{5'h01, 7'h5A, 8'hB6}, {5'h01, 7'h5A, 8'h34},
		{5'h01, 7'h5A, 8'h00}, {5'h01, 7'h00, 8'h00}, {5'h00, 7'h5A, 8'hB4}};
	// open drain wires
	assign scl = !(m_scl || scl_oe);
	assign sda = !(m_sda || sda_oe);
	always #4 clk = ~clk;
	tws_slave_unit tws_slave_unit_i (.SYS_CLK(clk), .RST_B(rst_b), .SCL_I(scl),
		.SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.BUS_FREE_REQUEST_N(bfr_n), .SOFT_RESET_BIT(srst), .CTL_WR(ctl_wr),
		.FREE_REQUEST_ENABLE(cf[4]), .STRETCH_ENABLE(cf[3]),
		.ASYNC_ADDR_DETECT_ENABLE(cf[2]), .FILTER_ENABLE(cf[1]),
		.COMMUNICATION_ENABLE(cf[0]), .OWN_ADDRESS_FIELD(own), .TX_DATA(txd),
		.TX_WR(tx_wr), .TX_EMPTY(tx_empty), .RX_DATA(rx_data), .RX_FULL(rx_full),
		.RX_RD(rx_rd), .BUSY(busy), .SELECTED(sel), .RW_DIR(rw),
		.FREE_REQUEST_FLAG(frf), .ASYNC_DET_FLAG(adf), .ASYNC_DET_CLR(aclr));
	tws_bm tws_bm_i (.scl_dn(m_scl), .sda_dn(m_sda), .scl(scl), .sda(sda), .hang(hang));
	// compare and count
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask
	// load controls
	task cfg(input logic [4:0] f, input logic [6:0] a);
		@(negedge clk);
		cf = f;
		own = a;
		ctl_wr = 1;
		@(negedge clk);
		ctl_wr = 0;
	endtask
	// start and address byte
	task adr(input logic [7:0] a);
		tws_bm_i.start;
		tws_bm_i.wrb(a, ack);
	endtask
	task t_write;
		cfg(5'h01, 7'h5A);
		tws_bm_i.start;
		#40 chk("busy", 1, busy);
		tws_bm_i.wrb(8'hB4, ack);
		chk("ack", 1, ack);
		chk("sel_rw", 2, {sel, rw});
		tws_bm_i.wrb(8'hC3, ack);
		#40 chk("rx", 8'hC3, rx_data);
		chk("full", 2, {rx_full, scl_oe});
		@(negedge clk) rx_rd = 1;
		@(negedge clk) rx_rd = 0;
		tws_bm_i.stop;
		chk("idle", 0, {busy, sel});
		$display("test write done");
	endtask
	task t_read;
		@(negedge clk) txd = 8'h96;
		tx_wr = 1;
		@(negedge clk) tx_wr = 0;
		adr(8'hB5);
		chk("rd_ack", 3, {ack, rw});
		tws_bm_i.rdb(1'b1, d);
		chk("tx", 8'h96, d);
		chk("t_emp", 1, tx_empty);
		tws_bm_i.stop;
		$display("test read done");
	endtask
	task t_table;
		for (int k = 0; k < 5; k++)
		begin
			cfg(tab[k][19:15], tab[k][14:8]);
			adr(tab[k][7:0]);
			// last entry matches with communication off: selected, but silent
			chk("nak", (k == 4) ? 8'h01 : 8'h00, {ack, sel});
			tws_bm_i.stop;
		end
		$display("test table done");
	endtask
	task t_stretch;
		cfg(5'h0B, 7'h5A);
		tws_bm_i.glitch;
		chk("glitch", 0, busy);
		adr(8'hB4);
		tws_bm_i.wrb(8'h3C, ack);
		#80 chk("hold", 2, {scl_oe, scl});
		chk("drv", 0, {scl_o, sda_o});
		chk("rx_f", 8'h3C, rx_data);
		@(negedge clk) rx_rd = 1;
		@(negedge clk) rx_rd = 0;
		#40 chk("free", 0, scl_oe);
		tws_bm_i.stop;
		$display("test stretch done");
	endtask
	task t_async;
		cfg(5'h05, 7'h5A);
		adr(8'hB4);
		chk("async", 1, {ack, adf});
		@(negedge clk) aclr = 1;
		@(negedge clk) aclr = 0;
		chk("aclr", 0, adf);
		tws_bm_i.stop;
		cfg(5'h01, 7'h5A);
		adr(8'hB4);
		chk("retry", 1, ack);
		tws_bm_i.stop;
		$display("test async done");
	endtask
	// low request for three cycles
	task bfr;
		@(negedge clk) bfr_n = 0;
		repeat (3) @(negedge clk);
		bfr_n = 1;
		#40;
	endtask
	task t_free;
		cfg(5'h09, 7'h5A);
		bfr;
		chk("off", 0, frf);
		cfg(5'h19, 7'h5A);
		adr(8'hB4);
		tws_bm_i.wrb(8'h55, ack);
		#80 chk("str", 1, scl_oe);
		bfr;
		chk("bfr", 2, {frf, scl_oe});
		tws_bm_i.stop;
		adr(8'hB4);
		chk("kept", 1, ack);
		tws_bm_i.stop;
		@(negedge clk) srst = 1;
		@(negedge clk) srst = 0;
		chk("srst", 0, frf);
		adr(8'hB4);
		chk("dflt", 0, ack);
		tws_bm_i.stop;
		$display("test free done");
	endtask
	// verdict
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// stretch that never ends
	always @(posedge hang)
	begin
		err_count++;
		wrap_up;
	end
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk) rst_b = 1;
		chk("reset", 0, {busy, sel, scl_oe, sda_oe, frf, adf, rx_full, rw});
		t_write;
		t_read;
		t_table;
		t_stretch;
		t_async;
		t_free;
		wrap_up;
	end
endmodule // test_tws_slave_unit
`default_nettype wire
